// file: hdl/spi_memory_command_front_end.sv
`timescale 1ns/1ns
`include "spi_fe_defs.svh"
module spi_memory_command_front_end
    import spi_fe_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input  wire logic              clock,       // System clock, 100 MHz
    input  wire logic              rst,         // Async reset, power-up delay
    input  wire logic              sck,         // Serial clock pin
    input  wire logic              cs_n,        // Chip select pin
    input  wire logic              si,          // Serial data in pin
    output logic                   so_out,      // Serial data out
    output logic                   so_oe,       // Output enable, high drives
    output logic                   mode3,       // Mode caught at select
    output cmd_t                   cmd,         // Decoded command
    output logic                   cmd_valid,   // One-cycle decode pulse
    output logic                   cmd_invalid, // One-cycle bad opcode pulse
    output logic [ADDR_W-1:0]      addr,        // Effective address
    output logic                   addr_valid,  // One-cycle address pulse
    output logic [7:0]             wr_data,     // Received data byte
    output logic                   wr_valid,    // One-cycle data byte pulse
    output logic                   write_latch_flag // Write enable latch
);
    //--------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------
    logic [1:0] sck_s;
    logic [1:0] cs_s;
    logic [1:0] si_s;
    logic       sck_d;
    logic       cs_d;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sck_s <= 2'h0;
            cs_s  <= 2'h3;
            si_s  <= 2'h0;
            sck_d <= 1'b0;
            cs_d  <= 1'b1;
        end
        else
        begin
            sck_s <= {sck_s[0], sck};
            cs_s  <= {cs_s[0], cs_n};
            si_s  <= {si_s[0], si};
            sck_d <= sck_s[1];
            cs_d  <= cs_s[1];
        end
    end
    logic sel;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    assign sel      = ~cs_s[1];
    assign cs_fall  = cs_d & ~cs_s[1];
    assign cs_rise  = ~cs_d & cs_s[1];
    assign sck_rise = sel & ~cs_fall & ~sck_d & sck_s[1];
    assign sck_fall = sel & sck_d & ~sck_s[1];

    function automatic cmd_t decode(input logic [7:0] op);
        unique case (op)
            `OP_SET_LATCH:    decode = CMD_SET;
            `OP_CLEAR_LATCH:  decode = CMD_CLEAR;
            `OP_STATUS_READ:  decode = CMD_STATUS_READ;
            `OP_STATUS_WRITE: decode = CMD_STATUS_WRITE;
            `OP_MEM_READ:     decode = CMD_READ;
            `OP_FAST_READ:    decode = CMD_FREAD;
            `OP_MEM_WRITE:    decode = CMD_WRITE;
            `OP_SLEEP:        decode = CMD_SLEEP;
            `OP_ID_READ:      decode = CMD_ID;
            default:          decode = CMD_NONE;
        endcase
    endfunction

    //--------------------------------------------------------------
    // Mode capture
    //--------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            mode3 <= 1'b0;
        else if (cs_fall)
            mode3 <= sck_s[1];
    end

    //--------------------------------------------------------------
    // Shifter and framing
    //--------------------------------------------------------------
    phase_t     phase;
    logic [2:0] bitcnt;
    logic [1:0] bytecnt;
    logic [7:0] shreg;
    logic [7:0] next_byte;
    assign next_byte = {shreg[6:0], si_s[1]};
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            phase       <= ST_OPCODE;
            bitcnt      <= 3'h0;
            bytecnt     <= 2'h0;
            shreg       <= 8'h00;
            cmd         <= CMD_NONE;
            cmd_valid   <= 1'b0;
            cmd_invalid <= 1'b0;
            addr        <= '0;
            addr_valid  <= 1'b0;
            wr_data     <= 8'h00;
            wr_valid    <= 1'b0;
        end
        else
        begin
            cmd_valid   <= 1'b0;
            cmd_invalid <= 1'b0;
            addr_valid  <= 1'b0;
            wr_valid    <= 1'b0;
            if (!sel || cs_fall)
            begin
                phase   <= ST_OPCODE;
                bitcnt  <= 3'h0;
                bytecnt <= 2'h0;
                if (cs_fall)
                    cmd <= CMD_NONE;
            end
            else if (sck_rise && phase != ST_IGNORE && phase != ST_STATUS)
            begin
                shreg  <= next_byte;
                bitcnt <= bitcnt + 3'h1;
                if (bitcnt == 3'h7)
                begin
                    unique case (phase)
                        ST_OPCODE:
                        begin
                            cmd <= decode(next_byte);
                            if (decode(next_byte) == CMD_NONE)
                            begin
                                cmd_invalid <= 1'b1;
                                phase       <= ST_IGNORE;
                            end
                            else
                            begin
                                cmd_valid <= 1'b1;
                                unique case (decode(next_byte))
                                    CMD_READ, CMD_FREAD, CMD_WRITE: phase <= ST_ADDR;
                                    CMD_STATUS_READ:  phase <= ST_STATUS;
                                    CMD_STATUS_WRITE: phase <= ST_DATA;
                                    default:   phase <= ST_IGNORE;
                                endcase
                            end
                        end
                        ST_ADDR:
                        begin
                            addr <= ADDR_W'({addr, next_byte});
                            bytecnt <= bytecnt + 2'h1;
                            if (bytecnt == 2'(`ADDR_BYTES - 1))
                            begin
                                addr_valid <= 1'b1;
                                phase      <= ST_DATA;
                            end
                        end
                        default:
                        begin
                            wr_data  <= next_byte;
                            wr_valid <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    //--------------------------------------------------------------
    // Write enable latch
    //--------------------------------------------------------------
    logic end_clears;
    assign end_clears = cmd == CMD_CLEAR || cmd == CMD_STATUS_WRITE || cmd == CMD_WRITE;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            write_latch_flag <= 1'b0;
        else if (cs_rise && end_clears)
            write_latch_flag <= 1'b0;
        else if (cmd_valid && cmd == CMD_SET)
            write_latch_flag <= 1'b1;
    end

    //--------------------------------------------------------------
    // Status output on falling edges
    //--------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] out_sh;
    logic       loaded;
    always_comb
    begin
        status = `STATUS_FIXED;
        status[`STATUS_LATCH_BIT] = write_latch_flag;
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            so_out <= 1'b0;
            so_oe  <= 1'b0;
            out_sh <= 8'h00;
            loaded <= 1'b0;
        end
        else if (!sel || phase != ST_STATUS)
        begin
            so_oe  <= 1'b0;
            loaded <= 1'b0;
        end
        else if (sck_fall)
        begin
            so_oe  <= 1'b1;
            so_out <= loaded ? out_sh[7] : status[7];
            out_sh <= loaded ? {out_sh[6:0], 1'b0} : {status[6:0], 1'b0};
            loaded <= 1'b1;
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    // Opcodes decoded since select, and silence after a bad opcode
    logic [1:0] ops_seen;
    logic       ignoring;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ops_seen <= 2'h0;
        else if (cs_fall)
            ops_seen <= 2'h0;
        else if ((cmd_valid || cmd_invalid) && ops_seen != 2'h3)
            ops_seen <= ops_seen + 2'h1;
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ignoring <= 1'b0;
        else if (cs_fall)
            ignoring <= 1'b0;
        else if (cmd_invalid)
            ignoring <= 1'b1;
    end
    property p_deselect_quiet;
        @(posedge clock) disable iff (rst) !sel |=> !so_oe;
    endproperty
    a_deselect_quiet: assert property (p_deselect_quiet) else $error("output on while off");
    property p_bad_op;
        @(posedge clock) disable iff (rst) cmd_invalid |-> phase == ST_IGNORE;
    endproperty
    a_bad_op: assert property (p_bad_op) else $error("bad opcode not ignored");
    property p_latch_clear;
        @(posedge clock) disable iff (rst) cs_rise && end_clears |=> !write_latch_flag;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");
    property p_latch_set;
        @(posedge clock) disable iff (rst)
            $rose(write_latch_flag) |-> $past(cmd_valid) && $past(cmd) == CMD_SET;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch set without command");
    property p_oe_status;
        @(posedge clock) disable iff (rst) so_oe |-> $past(phase) == ST_STATUS;
    endproperty
    a_oe_status: assert property (p_oe_status) else $error("output outside read");
    property p_mode;
        @(posedge clock) disable iff (rst) cs_fall |=> mode3 == $past(sck_s[1]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not captured");
    property p_one_op;
        @(posedge clock) disable iff (rst) cmd_valid |=> !cmd_valid;
    endproperty
    a_one_op: assert property (p_one_op) else $error("double opcode");
    property p_change_fall;
        @(posedge clock) disable iff (rst) so_oe && $changed(so_out) |-> $past(sck_fall);
    endproperty
    a_change_fall: assert property (p_change_fall) else $error("output moved off fall");
    property p_one_per_select;
        @(posedge clock) disable iff (rst) ops_seen <= 2'h1;
    endproperty
    a_one_per_select: assert property (p_one_per_select) else $error("opcode twice");
    property p_bad_op_quiet;
        @(posedge clock) disable iff (rst)
            ignoring |-> !cmd_valid && !addr_valid && !wr_valid && !so_oe;
    endproperty
    a_bad_op_quiet: assert property (p_bad_op_quiet) else $error("bad op acted");
    sequence s_last_op_bit;
        sck_rise && phase == ST_OPCODE && bitcnt == 3'h7;
    endsequence
    sequence s_op_verdict;
        cmd_valid ^ cmd_invalid;
    endsequence
    property p_decode_eighth;
        @(posedge clock) disable iff (rst) s_last_op_bit |=> s_op_verdict;
    endproperty
    a_decode_eighth: assert property (p_decode_eighth) else $error("no decode");
    sequence s_first_out_fall;
        sel && phase == ST_STATUS && sck_fall && !loaded;
    endsequence
    property p_status_first;
        @(posedge clock) disable iff (rst)
            s_first_out_fall |=> so_oe && so_out == $past(status[7]);
    endproperty
    a_status_first: assert property (p_status_first) else $error("status msb late");
    property p_latch_init;
        @(posedge clock) $fell(rst) |-> !write_latch_flag;
    endproperty
    a_latch_init: assert property (p_latch_init) else $error("latch set at reset");
endmodule

// file: hdl/spi_fe_defs.svh
// Operation
// - Sample input on rising, drive on falling
// - Clock level at select picks mode 0/3
// - Mode 3: first rise after low captures
// - First byte is opcode, one per select
// - Deselected: ignore input, output tristated
// - All bytes shifted most significant first
// - Three address bytes, low 18 bits used
// - Bad opcode: ignore rest, output off
// - Set, clear latch and status read codes
// - Status write, read, fast read codes
// - Memory write, sleep, identity read codes
// - Write latch cleared at power-up
// - Only set command sets the latch flag
// - Deselect after clear/write commands clears latch
// - Clear command blocks later writes; here wr_valid still fires with the latch flag clear
// - Latch flag reads one when writes allowed
// - Writes finish at bus speed, never busy
// - Output driven only for read data; here only status read drives it, memory reads and identity read never do
// - Latch flag at status bit 1
`ifndef SPI_FE_DEFS_SVH
`define SPI_FE_DEFS_SVH
`define OP_SET_LATCH    8'h06
`define OP_CLEAR_LATCH  8'h04
`define OP_STATUS_READ  8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_MEM_READ     8'h03
`define OP_FAST_READ    8'h0b
`define OP_MEM_WRITE    8'h02
`define OP_SLEEP        8'hb9
`define OP_ID_READ      8'h9f
`define STATUS_LATCH_BIT 1
`define STATUS_FIXED     8'h40
`define ADDR_BYTES       3
`endif

// file: hdl/spi_fe_pkg.sv
package spi_fe_pkg;
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_ADDR   = 3'b001,
        ST_DATA   = 3'b010,
        ST_STATUS = 3'b011,
        ST_IGNORE = 3'b100
    } phase_t;
    typedef enum logic [3:0] {
        CMD_NONE         = 4'h0,
        CMD_SET          = 4'h1,
        CMD_CLEAR        = 4'h2,
        CMD_STATUS_READ  = 4'h3,
        CMD_STATUS_WRITE = 4'h4,
        CMD_READ         = 4'h5,
        CMD_FREAD        = 4'h6,
        CMD_WRITE        = 4'h7,
        CMD_SLEEP        = 4'h8,
        CMD_ID           = 4'h9
    } cmd_t;
endpackage

// file: tb/spi_master_model.sv
`timescale 1ns/1ns
module spi_master_model
(
    input  wire logic clock, // Bench clock
    input  wire logic so,    // Data from device
    output logic      sck,   // Serial clock, 4 cycles a phase
    output logic      cs_n,  // Select, low in a frame
    output logic      si     // Data to device
);
    logic [7:0] rx;
    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
        rx   = 8'h00;
    end
    // Deselected data line carries noise
    always @(posedge clock)
        if (cs_n)
            si <= 1'($urandom);
    // Sends the top nbits of data; idle clock level picks the mode
    task automatic frame(input logic m3, input int nbits, input logic [39:0] data);
        sck <= m3;
        repeat (4) @(posedge clock);
        cs_n <= 1'b0;
        repeat (4) @(posedge clock);
        for (int i = 0; i < nbits; i++)
        begin
            sck <= 1'b0;
            si  <= data[39-i];
            repeat (4) @(posedge clock);
            sck <= 1'b1;
            repeat (4) @(posedge clock);
            rx <= {rx[6:0], so};
        end
        repeat (4) @(posedge clock);
        sck <= m3;
        repeat (4) @(posedge clock);
        cs_n <= 1'b1;
        repeat (6) @(posedge clock);
    endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
`include "spi_fe_defs.svh"
module testbench;
    import spi_fe_pkg::*;
    logic        clock, rst, filler, m, so, sck, cs_n, si, so_out, so_oe, mode3;
    logic        cmd_valid, cmd_invalid, addr_valid, wr_valid, write_latch_flag;
    cmd_t        cmd;
    logic [17:0] addr, last_addr;
    logic [7:0]  wr_data, last_data, op;
    logic [23:0] a;
    int          fails = 0, total_checks = 0, n_valid = 0, n_invalid = 0, oe_count = 0;
    int          nv, ni, n_oe, nl, latch_cycles = 0;
    logic [7:0]  ops[9] = '{`OP_SET_LATCH, `OP_CLEAR_LATCH, `OP_STATUS_READ, `OP_STATUS_WRITE,
                            `OP_MEM_READ, `OP_FAST_READ, `OP_MEM_WRITE, `OP_SLEEP, `OP_ID_READ};
    cmd_t        cmds[9] = '{CMD_SET, CMD_CLEAR, CMD_STATUS_READ, CMD_STATUS_WRITE, CMD_READ,
                             CMD_FREAD, CMD_WRITE, CMD_SLEEP, CMD_ID};
    spi_memory_command_front_end i_dut (.clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n),
        .si(si), .so_out(so_out), .so_oe(so_oe), .mode3(mode3), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_invalid(cmd_invalid), .addr(addr),
        .addr_valid(addr_valid), .wr_data(wr_data), .wr_valid(wr_valid),
        .write_latch_flag(write_latch_flag));
    spi_master_model i_master (.clock(clock), .so(so), .sck(sck), .cs_n(cs_n), .si(si));
    // Released output shows a toggling level, never a stale bit
    assign so = so_oe ? so_out : filler;
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ----------------------------------------
    // Monitors of pulses and captured values
    // ----------------------------------------
    always @(posedge clock)
    begin
        filler    <= ~filler;
        n_valid   <= n_valid + int'(cmd_valid);
        n_invalid <= n_invalid + int'(cmd_invalid);
        oe_count  <= oe_count + int'(so_oe);
        latch_cycles <= latch_cycles + int'(write_latch_flag);
        if (addr_valid)
            last_addr <= addr;
        if (wr_valid)
            last_data <= wr_data;
    end
    function automatic logic [7:0] status_exp(input logic latch);
        return `STATUS_FIXED | (8'(latch) << `STATUS_LATCH_BIT);
    endfunction
    function automatic logic latch_after(input logic [7:0] code);
        return !(code inside {`OP_CLEAR_LATCH, `OP_STATUS_WRITE, `OP_MEM_WRITE});
    endfunction
    function automatic logic known(input logic [7:0] code);
        foreach (ops[k])
            if (ops[k] == code)
                return 1'b1;
        return 1'b0;
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("Checks made: %0d, mismatches: %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #200_000;
        fails++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(81));
        rst    = 1'b1;
        filler = 1'b0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        repeat (20) @(posedge clock);
        check(24'(write_latch_flag), 24'h0, "latch after reset");
        for (int k = 0; k < 2; k++)
        begin
            n_oe = oe_count;
            i_master.frame(k[0], 16, {`OP_STATUS_READ, 32'h0});
            check(24'(i_master.rx), 24'(status_exp(1'b0)), "status");
            check(24'(mode3), 24'(k[0]), "mode");
            check(24'(oe_count > n_oe), 24'h1, "output driven");
            check(24'(so_oe), 24'h0, "output off when deselected");
        end
        foreach (ops[k])
        begin
            m = 1'($urandom);
            i_master.frame(m, 8, {`OP_SET_LATCH, 32'h0});
            check(24'(write_latch_flag), 24'h1, "latch set");
            nv = n_valid;
            i_master.frame(~m, 8, {ops[k], 32'h0});
            check(24'(n_valid - nv), 24'h1, "one decode");
            check(24'(cmd), 24'(cmds[k]), "command");
            check(24'(write_latch_flag), 24'(latch_after(ops[k])), "latch");
        end
        for (int k = 0; k < 4; k++)
        begin
            m  = 1'($urandom);
            a  = (k == 0) ? 24'hfc0000 : {6'h0, 18'($urandom)};
            op = 8'($urandom);
            i_master.frame(m, 8, {`OP_SET_LATCH, 32'h0});
            i_master.frame(m, 40, {`OP_MEM_WRITE, a, op});
            check(24'(last_addr), 24'(a[17:0]), "address");
            check(24'(last_data), 24'(op), "data byte");
            check(24'(write_latch_flag), 24'h0, "latch after write");
            nl = latch_cycles;
            i_master.frame(m, 16, {`OP_STATUS_WRITE, 8'h02, 24'h0});
            check(24'(write_latch_flag), 24'h0, "status write on flag");
            check(24'(latch_cycles - nl), 24'h0, "flag never set by data");
            check(24'(last_data), 24'h02, "status byte");
        end
        for (int k = 0; k < 3; k++)
        begin
            op = (k == 0) ? 8'h00 : 8'h06;
            while (known(op))
                op = 8'($urandom);
            nv   = n_valid;
            ni   = n_invalid;
            n_oe = oe_count;
            i_master.frame(1'($urandom), 16, {op, `OP_SET_LATCH, 24'h0});
            check(24'(n_invalid - ni), 24'h1, "bad opcode flagged");
            check(24'(n_valid - nv), 24'h0, "second byte ignored");
            check(24'(oe_count - n_oe), 24'h0, "output stays off");
            check(24'(write_latch_flag), 24'h0, "latch untouched");
        end
        nv = n_valid;
        i_master.frame(1'b0, 7, {`OP_SET_LATCH, 32'h0});
        check(24'(n_valid - nv), 24'h0, "partial byte");
        i_master.frame(1'b1, 8, {`OP_SET_LATCH, 32'h0});
        i_master.frame(1'b1, 16, {`OP_STATUS_READ, 32'h0});
        check(24'(i_master.rx), 24'(status_exp(1'b1)), "status with latch");
        i_master.frame(1'b0, 8, {`OP_CLEAR_LATCH, 32'h0});
        i_master.frame(1'b0, 16, {`OP_STATUS_READ, 32'h0});
        check(24'(i_master.rx), 24'(status_exp(1'b0)), "status after clear");
        print_verdict();
    end
endmodule
